// *** logic/pmseq_clk_gen.sv ***
// output clock shaper driven by edges of the synchronised source clock
// assumes the source runs well below pclk/6 so no edge is missed
`timescale 1ns/1ps
module pmseq_clk_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_edge,
    input wire pmseq_pkg::pmseq_clk_cfg_t cfg,
    output logic clk_out
);
    logic [3:0] edge_cnt;
    logic [2:0] frame;
    wire half_done = (edge_cnt >= cfg.div);
    // modulation keeps only frames 0..duty of every eight; each gated frame lasts half a period
    wire gated = cfg.stop || (cfg.mod_en && (frame > cfg.duty));

    // gating acts only while low, so no runt pulse reaches the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt <= 4'h0;
            frame <= 3'h0;
            clk_out <= 1'b0;
        end else if (src_edge) begin
            if (half_done) begin
                edge_cnt <= 4'h0;
                if (clk_out) begin
                    clk_out <= 1'b0;
                    frame <= frame + 3'h1;
                end else if (!gated) begin
                    clk_out <= 1'b1; // [RL14]
                end else if (!cfg.mod_en) begin
                    frame <= 3'h0;
                end else begin
                    frame <= frame + 3'h1;
                end
            end else begin
                edge_cnt <= edge_cnt + 4'h1;
            end
        end
    end
endmodule : pmseq_clk_gen

// *** logic/pmseq_defs.svh ***
// offsets, field positions and reset values of the power mode sequencer
// assumes a 32-bit apb slave with byte addresses on paddr[11:0]
`ifndef PMSEQ_DEFS_SVH
`define PMSEQ_DEFS_SVH

// ----------
// register offsets
// ----------
`define PMSEQ_OFF_MODE 12'h000
`define PMSEQ_OFF_EVSEL 12'h004
`define PMSEQ_OFF_BRKSEL 12'h008
`define PMSEQ_OFF_DZSEL 12'h00c
`define PMSEQ_OFF_STBYPER 12'h010
`define PMSEQ_OFF_SUSPPER 12'h014
`define PMSEQ_OFF_DOZEPER 12'h018
`define PMSEQ_OFF_SMISTAT 12'h01c
`define PMSEQ_OFF_CLKCTL 12'h020
`define PMSEQ_OFF_PWRCTL 12'h024
`define PMSEQ_OFF_STATUS 12'h028
`define PMSEQ_OFF_EVENTS 12'h02c

// ----------
// mode control fields
// ----------
`define PMSEQ_MODE_LSB 0
`define PMSEQ_DOZE_EN_BIT 4
`define PMSEQ_AUTO_WAKE_BIT 5
`define PMSEQ_SMI_EN_LSB 8
`define PMSEQ_RST_MODE 32'h0000_0020

// ----------
// smi status bits
// ----------
`define PMSEQ_SMI_STBY 0
`define PMSEQ_SMI_BREAK 1
`define PMSEQ_SMI_SUSP 2

// ----------
// clock control fields: cpu cfg [8:0], bus cfg [24:16], standby div
// ----------
`define PMSEQ_CPU_CFG_LSB 0
`define PMSEQ_BUS_CFG_LSB 16
`define PMSEQ_STBY_DIV_LSB 28
`define PMSEQ_RST_CLKCTL 32'h1001_0000

// ----------
// power control fields
// ----------
`define PMSEQ_STBY_OFF_LSB 0
`define PMSEQ_POS_KEEP_LSB 8
`define PMSEQ_POS_CACHE_BIT 16
`define PMSEQ_RST_PWRCTL 32'h0000_0000
`define PMSEQ_RST_ZERO 32'h0000_0000

`endif

// *** logic/pmseq_idle_timer.sv ***
// idle timer: reloads on a monitored event, pulses after a full period
// assumes event_hit comes from logic on pclk; period 0 keeps it silent
`timescale 1ns/1ps
module pmseq_idle_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] period,
    input wire logic enable,
    input wire logic event_hit,
    output logic expire
);
    logic [31:0] count;
    wire reload = !enable || event_hit;
    wire last = (count == 32'h0000_0001);

    // any event restarts the full period, so expiry needs quiet time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 32'h0000_0000;
            expire <= 1'b0;
        end else begin
            expire <= !reload && last; // [RL19]
            if (reload) begin
                count <= period; // [RL19]
            end else if (count != 32'h0000_0000) begin
                count <= count - 32'h0000_0001;
            end
        end
    end
endmodule : pmseq_idle_timer

// *** logic/pmseq_pkg.sv ***
// types shared by the power mode sequencer files
// assumes nothing beyond a systemverilog compiler
package pmseq_pkg;

    // ------------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PMSEQ_FULL_ON = 3'b000,
        PMSEQ_STANDBY = 3'b001,
        PMSEQ_FREEZE = 3'b010,
        PMSEQ_POS = 3'b011,
        PMSEQ_PDS = 3'b100
    } pmseq_mode_t;

    // ------------------------------------------------------------------
    // output clock shaping: divide by div+1 source edges per half period
    // ------------------------------------------------------------------
    typedef struct packed {
        logic stop;
        logic mod_en;
        logic [2:0] duty;
        logic [3:0] div;
    } pmseq_clk_cfg_t;

    // ------------------------------------------------------------------
    // supply controls
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cpu_on;
        logic cache_on;
        logic dev_standby;
        logic [7:0] periph_on;
    } pmseq_pwr_t;

endpackage : pmseq_pkg

// *** logic/pmseq_top.sv ***
// power mode sequencer: modes, idle timers, smi requests, clock shaping
// assumes an apb master on pclk and asynchronous event and clock pins
`timescale 1ns/1ps
`include "pmseq_defs.svh"

// Summary of operation
// RL1: reset leaves full-on mode, full-speed cpu clock, all supplies on.
// RL2: thirty-one event inputs, each selectable as a timer monitor source.
// RL3: standby may be entered after selected events stay quiet a period.
// RL4: in standby a selected break event returns the system to full-on.
// RL5: standby runs a slower cpu clock and can cut chosen peripherals.
// RL6: doze can be enabled only in full-on or standby.
// RL7: enabled doze reduces cpu power by itself on detected idleness.
// RL8: software picks the next mode; hardware only raises triggers; with auto_wake set the code itself returns to full-on on a break event.
// RL9: three suspend variants: freeze, powered suspend, unpowered suspend.
// RL10: freeze keeps everything powered, devices idle, clocks stopped.
// RL11: powered suspend cuts cpu and cache, keeps selected devices; the code keeps cache on when pos_cache (pwr_ctrl bit 16) is set.
// RL12: unpowered suspend removes every supply this block controls.
// RL13: full-on gives cpu clock source divided by one, bus by two.
// RL14: cpu and bus clocks scale, modulate or stop independently.
// RL15: doze idleness asserts the stop clock request to the cpu.
// RL16: standby timer raises an smi when selected events stay quiet.
// RL17: a break event in standby raises a further smi.
// RL18: enabled auto-suspend timer raises an smi after its idle period.
// RL19: idle timers reload on any selected event, fire after full period.
// RL20: reset restores full-power defaults and full clock ratios.
module pmseq_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [30:0] sys_event,
    input wire logic source_clock_in,
    output logic cpu_clock_out,
    output logic bus_clock_out,
    output logic cpu_stop_clock_request,
    output logic smi_request,
    output pmseq_pkg::pmseq_pwr_t power_ctrl
);
    // ----------
    // registers and state
    // ----------
    logic [31:0] mode_ctrl;
    logic [30:0] event_sel;
    logic [30:0] break_sel;
    logic [30:0] doze_sel;
    logic [31:0] stby_period;
    logic [31:0] susp_period;
    logic [31:0] doze_period;
    logic [2:0] smi_status;
    logic [31:0] clk_ctrl;
    logic [31:0] pwr_ctrl;
    pmseq_pkg::pmseq_mode_t mode;
    pmseq_pkg::pmseq_mode_t next_mode;
    logic doze_active;
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] sync3;
    logic [31:0] filt;
    logic src_d;
    logic stby_expire;
    logic susp_expire;
    logic doze_expire;

    // ----------
    // input synchronisers
    // ----------
    // three stages; a bit changes only when stages two and three agree,
    // which rejects a single metastable sample at the cost of latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= `PMSEQ_RST_ZERO;
            sync2 <= `PMSEQ_RST_ZERO;
            sync3 <= `PMSEQ_RST_ZERO;
            filt <= `PMSEQ_RST_ZERO;
            src_d <= 1'b0;
        end else begin
            sync1 <= {source_clock_in, sys_event};
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
            src_d <= filt[31];
        end
    end

    wire [30:0] activity = filt[30:0];
    wire src_edge = filt[31] ^ src_d;

    // ----------
    // apb decode
    // ----------
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `PMSEQ_OFF_EVENTS);
    endfunction : mapped

    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready && pwrite && !pslverr;
    wire wr_mode = wr_en && (paddr == `PMSEQ_OFF_MODE);
    wire wr_evsel = wr_en && (paddr == `PMSEQ_OFF_EVSEL);
    wire wr_brksel = wr_en && (paddr == `PMSEQ_OFF_BRKSEL);
    wire wr_dzsel = wr_en && (paddr == `PMSEQ_OFF_DZSEL);
    wire wr_stbyper = wr_en && (paddr == `PMSEQ_OFF_STBYPER);
    wire wr_suspper = wr_en && (paddr == `PMSEQ_OFF_SUSPPER);
    wire wr_dozeper = wr_en && (paddr == `PMSEQ_OFF_DOZEPER);
    wire wr_smistat = wr_en && (paddr == `PMSEQ_OFF_SMISTAT);
    wire wr_clkctl = wr_en && (paddr == `PMSEQ_OFF_CLKCTL);
    wire wr_pwrctl = wr_en && (paddr == `PMSEQ_OFF_PWRCTL);

    // ----------
    // mode control fields
    // ----------
    wire doze_en = mode_ctrl[`PMSEQ_DOZE_EN_BIT];
    wire auto_wake = mode_ctrl[`PMSEQ_AUTO_WAKE_BIT];
    wire [2:0] smi_en = mode_ctrl[`PMSEQ_SMI_EN_LSB +: 3];
    wire [2:0] req_code = pwdata[`PMSEQ_MODE_LSB +: 3];
    wire req_legal = (req_code <= 3'h4);
    wire in_full = (mode == pmseq_pkg::PMSEQ_FULL_ON);
    wire in_stby = (mode == pmseq_pkg::PMSEQ_STANDBY);

    // ----------
    // event matching
    // ----------
    wire stby_hit = |(activity & event_sel); // [RL2]
    wire break_hit = |(activity & break_sel) && in_stby;
    wire doze_hit = |(activity & doze_sel);
    wire doze_allowed = doze_en && (in_full || in_stby); // [RL6]

    // ----------
    // idle timers
    // ----------
    // the standby timer watches only while fully on
    pmseq_idle_timer u_stby_timer (
        .pclk(pclk),
        .presetn(presetn),
        .period(stby_period),
        .enable(in_full),
        .event_hit(stby_hit),
        .expire(stby_expire)
    );

    // auto-suspend counts idleness only once standby has been entered
    pmseq_idle_timer u_susp_timer (
        .pclk(pclk),
        .presetn(presetn),
        .period(susp_period),
        .enable(in_stby),
        .event_hit(stby_hit),
        .expire(susp_expire)
    );

    // doze timer is held in reload while doze is already active
    pmseq_idle_timer u_doze_timer (
        .pclk(pclk),
        .presetn(presetn),
        .period(doze_period),
        .enable(doze_allowed && !doze_active),
        .event_hit(doze_hit),
        .expire(doze_expire)
    );

    // ----------
    // next mode
    // ----------
    // a legal software write wins over the automatic wake in the same cycle;
    // an illegal mode code is ignored, so a wake in that cycle still applies
    always_comb begin
        next_mode = mode;
        if (wr_mode && req_legal) begin
            next_mode = pmseq_pkg::pmseq_mode_t'(req_code); // [RL8] [RL3]
        end else if (break_hit && auto_wake) begin
            next_mode = pmseq_pkg::PMSEQ_FULL_ON; // [RL4]
        end
    end

    // ----------
    // register writes
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctrl <= `PMSEQ_RST_MODE;
            event_sel <= 31'h0000_0000;
            break_sel <= 31'h0000_0000;
            doze_sel <= 31'h0000_0000;
            stby_period <= `PMSEQ_RST_ZERO;
            susp_period <= `PMSEQ_RST_ZERO;
            doze_period <= `PMSEQ_RST_ZERO;
            clk_ctrl <= `PMSEQ_RST_CLKCTL; // [RL20]
            pwr_ctrl <= `PMSEQ_RST_PWRCTL;
        end else begin
            if (wr_mode) mode_ctrl <= pwdata & 32'h0000_0730;
            if (wr_evsel) event_sel <= pwdata[30:0];
            if (wr_brksel) break_sel <= pwdata[30:0];
            if (wr_dzsel) doze_sel <= pwdata[30:0];
            if (wr_stbyper) stby_period <= pwdata;
            if (wr_suspper) susp_period <= pwdata;
            if (wr_dozeper) doze_period <= pwdata;
            if (wr_clkctl) clk_ctrl <= pwdata & 32'hf1ff_01ff;
            if (wr_pwrctl) pwr_ctrl <= pwdata & 32'h0001_ffff;
        end
    end

    // ----------
    // mode, doze and smi state
    // ----------
    // status bits are write-one-to-clear and a new event beats the clear
    wire [2:0] smi_set = {susp_expire, break_hit, stby_expire};
    wire [2:0] smi_clr = wr_smistat ? pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= pmseq_pkg::PMSEQ_FULL_ON; // [RL1]
            doze_active <= 1'b0;
            smi_status <= 3'h0;
            smi_request <= 1'b0;
        end else begin
            mode <= next_mode;
            if (!doze_allowed || doze_hit) begin
                doze_active <= 1'b0;
            end else if (doze_expire) begin
                doze_active <= 1'b1; // [RL7]
            end
            smi_status <= smi_set | (smi_status & ~smi_clr); // [RL16] [RL17] [RL18]
            smi_request <= |(smi_status & smi_en);
        end
    end

    // ----------
    // clock selection
    // ----------
    wire pmseq_pkg::pmseq_clk_cfg_t cpu_cfg_reg =
        clk_ctrl[`PMSEQ_CPU_CFG_LSB +: 9];
    wire pmseq_pkg::pmseq_clk_cfg_t bus_cfg_reg =
        clk_ctrl[`PMSEQ_BUS_CFG_LSB +: 9];
    wire [3:0] stby_div = clk_ctrl[`PMSEQ_STBY_DIV_LSB +: 4];
    wire clocks_run = in_full || in_stby;
    pmseq_pkg::pmseq_clk_cfg_t cpu_cfg;
    pmseq_pkg::pmseq_clk_cfg_t bus_cfg;

    // reset ratios give source/1 and source/2; suspend modes stop both
    always_comb begin
        cpu_cfg = cpu_cfg_reg; // [RL13]
        bus_cfg = bus_cfg_reg; // [RL13]
        if (in_stby) begin
            cpu_cfg.div = stby_div; // [RL5]
        end
        if (!clocks_run) begin
            cpu_cfg.stop = 1'b1; // [RL10]
            bus_cfg.stop = 1'b1;
        end
    end

    pmseq_clk_gen u_cpu_clk (
        .pclk(pclk),
        .presetn(presetn),
        .src_edge(src_edge),
        .cfg(cpu_cfg),
        .clk_out(cpu_clock_out)
    );

    pmseq_clk_gen u_bus_clk (
        .pclk(pclk),
        .presetn(presetn),
        .src_edge(src_edge),
        .cfg(bus_cfg),
        .clk_out(bus_clock_out)
    );

    // ----------
    // supply controls per mode
    // ----------
    wire [7:0] stby_off = pwr_ctrl[`PMSEQ_STBY_OFF_LSB +: 8];
    wire [7:0] pos_keep = pwr_ctrl[`PMSEQ_POS_KEEP_LSB +: 8];
    wire pos_cache = pwr_ctrl[`PMSEQ_POS_CACHE_BIT];
    pmseq_pkg::pmseq_pwr_t next_power;

    always_comb begin
        next_power = '{cpu_on: 1'b1, cache_on: 1'b1, dev_standby: 1'b0,
                       periph_on: 8'hff};
        unique case (next_mode) // [RL9]
            pmseq_pkg::PMSEQ_FULL_ON: begin
            end
            pmseq_pkg::PMSEQ_STANDBY: begin
                next_power.periph_on = ~stby_off; // [RL5]
            end
            pmseq_pkg::PMSEQ_FREEZE: begin
                next_power.dev_standby = 1'b1; // [RL10]
            end
            pmseq_pkg::PMSEQ_POS: begin
                next_power.cpu_on = 1'b0; // [RL11]
                next_power.cache_on = pos_cache;
                next_power.periph_on = pos_keep;
            end
            pmseq_pkg::PMSEQ_PDS: begin
                next_power.cpu_on = 1'b0; // [RL12]
                next_power.cache_on = 1'b0;
                next_power.periph_on = 8'h00;
            end
        endcase
    end

    // ----------
    // output flops
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_ctrl <= '{cpu_on: 1'b1, cache_on: 1'b1, dev_standby: 1'b0,
                            periph_on: 8'hff}; // [RL1]
            cpu_stop_clock_request <= 1'b0;
        end else begin
            power_ctrl <= next_power;
            cpu_stop_clock_request <= doze_active && doze_allowed; // [RL15]
        end
    end

    // ----------
    // apb read and answer
    // ----------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = `PMSEQ_RST_ZERO;
        unique case (paddr)
            `PMSEQ_OFF_MODE: rd_mux = mode_ctrl;
            `PMSEQ_OFF_EVSEL: rd_mux = {1'b0, event_sel};
            `PMSEQ_OFF_BRKSEL: rd_mux = {1'b0, break_sel};
            `PMSEQ_OFF_DZSEL: rd_mux = {1'b0, doze_sel};
            `PMSEQ_OFF_STBYPER: rd_mux = stby_period;
            `PMSEQ_OFF_SUSPPER: rd_mux = susp_period;
            `PMSEQ_OFF_DOZEPER: rd_mux = doze_period;
            `PMSEQ_OFF_SMISTAT: rd_mux = {29'h0000_0000, smi_status};
            `PMSEQ_OFF_CLKCTL: rd_mux = clk_ctrl;
            `PMSEQ_OFF_PWRCTL: rd_mux = pwr_ctrl;
            `PMSEQ_OFF_STATUS: rd_mux = {8'h00, power_ctrl.periph_on,
                5'h00, power_ctrl.dev_standby, power_ctrl.cache_on,
                power_ctrl.cpu_on, 2'h0, cpu_stop_clock_request,
                doze_active, 1'b0, mode};
            `PMSEQ_OFF_EVENTS: rd_mux = {1'b0, activity};
            default: rd_mux = `PMSEQ_RST_ZERO;
        endcase
    end

    // one wait-free access phase: answer is prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `PMSEQ_RST_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped(paddr);
            if (setup) prdata <= pwrite ? `PMSEQ_RST_ZERO : rd_mux;
        end
    end

endmodule : pmseq_top

// *** tb/pmseq_host_model.sv ***
// host side: free running clock source and smi handler entry count
// assumes the sequencer samples source_clock_in on pclk
`timescale 1ns/1ps
module pmseq_host_model (
    input wire logic smi_request,
    output logic source_clock_in,
    output int smi_seen
);
    // oscillator runs free; 80 ns keeps it below pclk/8
    initial begin
        source_clock_in = 1'b0;
        forever #40 source_clock_in = ~source_clock_in;
    end
    // each request enters the handler once; the bench picks the mode
    initial smi_seen = 0;
    always @(posedge smi_request) smi_seen++;
endmodule : pmseq_host_model

// *** tb/pmseq_top_props.sv ***
// port assertions for the power mode sequencer, bound onto pmseq_top
// assumes one pclk domain and an async active low presetn
`timescale 1ns/1ps
module pmseq_top_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_clock_out,
    input wire logic bus_clock_out,
    input wire logic cpu_stop_clock_request,
    input wire logic smi_request,
    input wire pmseq_pkg::pmseq_pwr_t power_ctrl
);
    // suspended: devices idled or cpu unpowered
    wire logic susp = power_ctrl.dev_standby || !power_ctrl.cpu_on;
    // only a status or mode write may drop the smi request
    wire logic clr_wr = psel && penable && pwrite &&
        (paddr == 12'h01c || paddr == 12'h000);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_zero_a: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("error read not zero");
    reset_power_a: assert property (
        !$past(presetn) |-> power_ctrl == 11'h6ff && !smi_request)
        else $error("power not at defaults after reset");
    clocks_low_a: assert property (
        !$past(presetn) |-> !cpu_clock_out && !bus_clock_out)
        else $error("clocks not low after reset");
    smi_clear_a: assert property (
        $fell(smi_request) |-> $past(clr_wr) || $past(clr_wr, 2) ||
        $past(clr_wr, 3))
        else $error("smi dropped without software");
    doze_gated_a: assert property (
        susp && $past(susp) && $past(susp, 2) && $past(susp, 3)
        |-> !cpu_stop_clock_request)
        else $error("stop clock while suspended");
    cover property ($rose(smi_request));
    cover property ($rose(cpu_stop_clock_request));
    cover property (pslverr);
    cover property (susp);
endmodule : pmseq_top_props

bind pmseq_top pmseq_top_props u_pmseq_top_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_clock_out(cpu_clock_out),
    .bus_clock_out(bus_clock_out),
    .cpu_stop_clock_request(cpu_stop_clock_request),
    .smi_request(smi_request), .power_ctrl(power_ctrl)
);

// *** tb/tb.sv ***
// bench for the power mode sequencer: apb sequences with expectations
// assumes the host model supplies the free running source clock
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic cpu_clock_out, bus_clock_out, cpu_stop_clock_request;
    logic smi_request, source_clock_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [30:0] sys_event;
    pmseq_pkg::pmseq_pwr_t power_ctrl;
    int smi_seen, cpu_r, bus_r;
    int miscompares = 0;
    int checked = 0;
    logic [31:0] cfgs [5] = '{32'h1001_0000, 32'h1101_0000, 32'h1001_0100,
        32'h1001_0001, 32'h1001_0000};
    int ecs [5] = '{20, 20, 0, 10, 20};
    int ebs [5] = '{10, 0, 10, 10, 10};

    pmseq_top u_pmseq_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_event(sys_event), .source_clock_in(source_clock_in),
        .cpu_clock_out(cpu_clock_out), .bus_clock_out(bus_clock_out),
        .cpu_stop_clock_request(cpu_stop_clock_request),
        .smi_request(smi_request), .power_ctrl(power_ctrl));
    pmseq_host_model u_pmseq_host_model (.smi_request(smi_request),
        .source_clock_in(source_clock_in), .smi_seen(smi_seen));

    // pclk at 200 MHz
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // rising edges of the output clocks, for rate checks
    always @(posedge cpu_clock_out) cpu_r++;
    always @(posedge bus_clock_out) bus_r++;

    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] x);
        checked++;
        if (s !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // one apb transfer; the trailing edge lets write effects land
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 16) chk("apb ready", pready, 1'b1);
    endtask : acc
    task automatic rdchk(input string nm, input logic [11:0] a,
        input logic [31:0] x);
        acc(1'b0, a, 32'h0000_0000);
        chk(nm, q, x);
    endtask : rdchk
    // event pulse, long enough to pass the input filter
    task automatic ev(input int i);
        sys_event[i] <= 1'b1;
        repeat (6) @(posedge pclk);
        sys_event[i] <= 1'b0;
        repeat (14) @(posedge pclk);
    endtask : ev
    // bounded wait for smi (0) or stop clock request (1)
    task automatic wup(input int w);
        for (int i = 0; i < 80 && (w ? cpu_stop_clock_request :
            smi_request) !== 1'b1; i++) @(posedge pclk);
    endtask : wup
    // counting over whole source periods makes the rise counts exact
    task automatic rate(input logic [31:0] cfg, input int ec, input int eb);
        int c0, b0;
        acc(1'b1, 12'h020, cfg);
        repeat (3) @(posedge source_clock_in);
        c0 = cpu_r;
        b0 = bus_r;
        repeat (20) @(posedge source_clock_in);
        chk("cpu rises", cpu_r - c0, ec);
        chk("bus rises", bus_r - b0, eb);
    endtask : rate
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // watchdog, several times the expected run
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
    // main sequence; the bench plays the smi handler choosing modes
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        sys_event = 31'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk("power", power_ctrl, 11'h6ff);
        rdchk("mode", 12'h000, 32'h0000_0020);
        acc(1'b1, 12'h030, 32'h0000_0001);
        chk("unmapped", e, 1'b1);
        rdchk("unaligned", 12'h002, 32'h0000_0000);
        chk("unaligned err", e, 1'b1);
        foreach (cfgs[i]) rate(cfgs[i], ecs[i], ebs[i]);
        acc(1'b1, 12'h004, 32'h4000_0000);
        acc(1'b1, 12'h008, 32'h0000_0002);
        acc(1'b1, 12'h010, 32'h0000_0028);
        acc(1'b1, 12'h000, 32'h0000_0720);
        repeat (5) ev(30);
        repeat (20) @(posedge pclk);
        chk("smi early", smi_request, 1'b0);
        wup(0);
        rdchk("stby smi", 12'h01c, 32'h0000_0001);
        acc(1'b1, 12'h010, 32'h0000_0000);
        acc(1'b1, 12'h01c, 32'h0000_0001);
        acc(1'b1, 12'h024, 32'h0000_000f);
        acc(1'b1, 12'h000, 32'h0000_0721);
        chk("stby periph", power_ctrl.periph_on, 8'hf0);
        ev(1);
        chk("woken periph", power_ctrl.periph_on, 8'hff);
        rdchk("break smi", 12'h01c, 32'h0000_0002);
        acc(1'b1, 12'h01c, 32'h0000_0002);
        acc(1'b1, 12'h014, 32'h0000_001e);
        acc(1'b1, 12'h000, 32'h0000_0721);
        wup(0);
        rdchk("susp smi", 12'h01c, 32'h0000_0004);
        acc(1'b1, 12'h014, 32'h0000_0000);
        acc(1'b1, 12'h01c, 32'h0000_0004);
        chk("smi count", smi_seen, 3);
        acc(1'b1, 12'h00c, 32'h0000_0004);
        acc(1'b1, 12'h018, 32'h0000_0014);
        acc(1'b1, 12'h000, 32'h0000_0730);
        wup(1);
        chk("doze stop", cpu_stop_clock_request, 1'b1);
        sys_event[2] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("doze wake", cpu_stop_clock_request, 1'b0);
        sys_event[2] <= 1'b0;
        acc(1'b1, 12'h024, 32'h0000_0300);
        acc(1'b1, 12'h000, 32'h0000_0732);
        chk("freeze power", power_ctrl, 11'h7ff);
        rate(32'h1001_0000, 0, 0);
        chk("freeze doze", cpu_stop_clock_request, 1'b0);
        acc(1'b1, 12'h000, 32'h0000_0733);
        chk("pos power", {power_ctrl.cpu_on, power_ctrl.cache_on,
            power_ctrl.periph_on}, 10'h003);
        acc(1'b1, 12'h000, 32'h0000_0734);
        chk("pds power", power_ctrl, 11'h000);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset power", power_ctrl, 11'h6ff);
        rdchk("reset clk", 12'h020, 32'h1001_0000);
        give_verdict();
    end
endmodule : tb
